// File: hwl_ers_src.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------
// external reset/trigger source
// --------------------------------
module hwl_ers_src (
    input wire logic clock_i,
    output logic ers_o
);
    int cyc_q = 0;
    int last_q = -8;
    initial ers_o = 1'b0;
    // free cycle count, used to space pin changes
    always @(posedge clock_i) begin
        cyc_q <= cyc_q + 1;
    end
    task automatic drive(input logic v);
        while (cyc_q - last_q < 6) @(posedge clock_i);
        ers_o <= v;
        last_q = cyc_q;
    endtask
endmodule // hwl_ers_src
`default_nettype wire

// File: hwl_pkg.sv
package hwl_pkg;

    // control register contents
    typedef struct packed {
        logic run_enable;
        logic [4:0] mode;
        logic [3:0] postscale_select;
    } hwl_ctrl_t;

    // mode classes held in mode[4:3]
    typedef enum logic [1:0] {
        HWL_CLS_FREE = 2'h0,
        HWL_CLS_ONESHOT = 2'h1,
        HWL_CLS_MONO = 2'h2,
        HWL_CLS_RSVD = 2'h3
    } hwl_class_t;

    // per-cycle decision of the mode decoder
    typedef struct packed {
        logic run;
        logic clear;
        logic arm;
        logic stop_on_match;
        logic drop_run_enable;
    } hwl_act_t;

endpackage : hwl_pkg

// File: hwl_regs.svh
`ifndef HWL_REGS_SVH
`define HWL_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define HWL_CTRL_OFS 8'h00
`define HWL_PERIOD_OFS 8'h04
`define HWL_COUNT_OFS 8'h08
`define HWL_STATUS_OFS 8'h0c

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define HWL_MODE_LSB 0
`define HWL_MODE_MSB 4
`define HWL_RUN_BIT 7
`define HWL_POST_LSB 8
`define HWL_POST_MSB 11

// ----------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------
`define HWL_ST_ON_BIT 0
`define HWL_ST_ARMED_BIT 1
`define HWL_ST_EXT_BIT 2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define HWL_PERIOD_RST 8'hff
`define HWL_MODE_RST 5'h00
`define HWL_POST_RST 4'h0
`define HWL_SYNC_STAGES 2

`endif

// File: hwl_timer_mode_ctrl.sv
// Function
// RULE_01: decode five-bit mode into class and sub-mode
// RULE_02: edge triggers spaced six timer clocks apart
// RULE_03: trigger levels held three timer clocks
// RULE_04: debug mode ignores external trigger events
// RULE_05: software gate counts while run-enable set
// RULE_06: free-running match returns count to zero
// RULE_07: hardware gate needs active external level
// RULE_08: free-running edge resets the count
// RULE_09: free-running level holds count in reset
// RULE_10: software start one-shot on run-enable
// RULE_11: one-shot starts on qualifying external edge
// RULE_12: first edge starts, later edges reset
// RULE_13: edge starts, opposite level holds reset
// RULE_14: one-shot match clears run-enable, stops zero
// RULE_15: monostable match stops, run-enable stays set
// RULE_16: level one-shot runs on active level
// RULE_17: edge modes need fresh edge after restart
// RULE_18: reserved modes leave counter stopped
// RULE_19: run-enable and external signal two-stage synced
// RULE_20: postscaler match gives one-clock pulse, clears
// RULE_21: reset clears count, period loads all ones
// RULE_22: level reset release resumes two clocks later
// RULE_23: external signal ignored while run-enable clear
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "hwl_regs.svh"

module hwl_timer_mode_ctrl #(
    parameter int CNT_W = 8,
    parameter int POST_W = 4
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // external reset/trigger pin and debug state
    input wire logic ext_reset_trigger_i,
    input wire logic debug_mode_i,
    // timer outputs
    output logic [CNT_W-1:0] count_value_o,
    output logic period_match_o,
    output logic postscaled_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    hwl_pkg::hwl_ctrl_t ctrl_ff; // software control fields
    logic [CNT_W-1:0] period_value_ff; // period limit
    logic [CNT_W-1:0] count_ff; // timer count
    logic [POST_W-1:0] post_cnt_ff; // postscaler count
    logic [`HWL_SYNC_STAGES-1:0] on_pipe_ff; // run-enable delay
    logic ers_meta_ff; // first sync stage, read by ers_sync_ff only
    logic ers_sync_ff; // synchronised pin
    logic ers_eff_ff; // pin as seen by the modes, frozen in debug
    logic ers_prev_ff; // previous effective level for edges
    logic armed_ff; // edge-started modes: start edge seen
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic match_pulse_ff;
    logic post_pulse_ff;
    logic on_sync; // run-enable after the sync delay
    logic rise; // qualified rising edge
    logic fall; // qualified falling edge
    logic match; // count equals period
    logic apb_wr; // write taken this cycle
    logic apb_rd; // read taken this cycle
    logic wr_ctrl;
    logic wr_count;
    hwl_pkg::hwl_act_t act; // decoder output
    hwl_pkg::hwl_class_t cls; // mode class
    logic [2:0] sub; // sub-mode

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // true when the address hits a mapped register
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `HWL_CTRL_OFS) || (a == `HWL_PERIOD_OFS) ||
            (a == `HWL_COUNT_OFS) || (a == `HWL_STATUS_OFS);
    endfunction

    // selects rising, falling or either edge from a two-bit code
    function automatic logic edge_sel(input logic [1:0] kind,
        input logic r, input logic f);
        case (kind)
            2'h1: edge_sel = r;
            2'h2: edge_sel = f;
            2'h3: edge_sel = r | f;
            default: edge_sel = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // apb access decode
    // ----------------------------------------------------------------
    // one wait state: the access phase sees pready one edge later
    assign apb_wr = psel_i & penable_i & pready_ff & pwrite_i;
    assign apb_rd = psel_i & penable_i & ~pready_ff & ~pwrite_i;
    assign wr_ctrl = apb_wr & (paddr_i == `HWL_CTRL_OFS);
    assign wr_count = apb_wr & (paddr_i == `HWL_COUNT_OFS);

    // ready and error answer, held for one cycle
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel_i & penable_i & ~pready_ff;
            pslverr_ff <= psel_i & penable_i & ~pready_ff &
                ~addr_hit(paddr_i);
        end
    end

    // read data captured on the same edge that raises pready
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata_ff <= 32'h0000_0000;
            case (paddr_i)
                `HWL_CTRL_OFS: begin
                    prdata_ff[`HWL_MODE_MSB:`HWL_MODE_LSB] <= ctrl_ff.mode;
                    prdata_ff[`HWL_RUN_BIT] <= ctrl_ff.run_enable;
                    prdata_ff[`HWL_POST_MSB:`HWL_POST_LSB] <=
                        ctrl_ff.postscale_select;
                end
                `HWL_PERIOD_OFS: prdata_ff[CNT_W-1:0] <= period_value_ff;
                `HWL_COUNT_OFS: prdata_ff[CNT_W-1:0] <= count_ff;
                `HWL_STATUS_OFS: begin
                    prdata_ff[`HWL_ST_ON_BIT] <= on_sync;
                    prdata_ff[`HWL_ST_ARMED_BIT] <= armed_ff;
                    prdata_ff[`HWL_ST_EXT_BIT] <= ers_sync_ff;
                end
                default: prdata_ff <= 32'h0000_0000; // unmapped reads zero
            endcase
        end else begin
            // data stands for the pready cycle only, so a refused write
            // never answers with stale read data
            prdata_ff <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // control and period registers
    // ----------------------------------------------------------------
    // a software write in the same cycle as the hardware clear wins,
    // so a restart issued right at the match is not lost
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ff.run_enable <= 1'b0;
            ctrl_ff.mode <= `HWL_MODE_RST;
            ctrl_ff.postscale_select <= `HWL_POST_RST;
        end else if (wr_ctrl) begin
            ctrl_ff.run_enable <= pwdata_i[`HWL_RUN_BIT];
            ctrl_ff.mode <= pwdata_i[`HWL_MODE_MSB:`HWL_MODE_LSB];
            ctrl_ff.postscale_select <=
                pwdata_i[`HWL_POST_MSB:`HWL_POST_LSB];
        // RULE_14: one-shot drops run-enable
        end else if (act.drop_run_enable && match && act.run) begin
            ctrl_ff.run_enable <= 1'b0;
        end
    end

    // RULE_21: period loads all ones on reset
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            period_value_ff <= CNT_W'(`HWL_PERIOD_RST);
        end else if (apb_wr && paddr_i == `HWL_PERIOD_OFS) begin
            period_value_ff <= pwdata_i[CNT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    // RULE_19: run-enable reaches the counter two clocks later
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            on_pipe_ff <= '0;
        end else begin
            on_pipe_ff <= {on_pipe_ff[`HWL_SYNC_STAGES-2:0],
                ctrl_ff.run_enable};
        end
    end
    assign on_sync = on_pipe_ff[`HWL_SYNC_STAGES-1] & ctrl_ff.run_enable;

    // RULE_19: pin passes two flip-flops
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ers_meta_ff <= 1'b0;
            ers_sync_ff <= 1'b0;
        end else begin
            ers_meta_ff <= ext_reset_trigger_i;
            ers_sync_ff <= ers_meta_ff;
        end
    end

    // RULE_04: debug freezes the level, so no edge or change is seen
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ers_eff_ff <= 1'b0;
            ers_prev_ff <= 1'b0;
        end else begin
            if (!debug_mode_i) begin
                ers_eff_ff <= ers_sync_ff;
            end
            ers_prev_ff <= ers_eff_ff;
        end
    end

    // RULE_23: edges only count while running is enabled
    assign rise = on_sync & ers_eff_ff & ~ers_prev_ff;
    assign fall = on_sync & ~ers_eff_ff & ers_prev_ff;
    assign match = (count_ff == period_value_ff);

    // ----------------------------------------------------------------
    // mode decoder
    // ----------------------------------------------------------------
    // RULE_01: class in the upper two bits, sub-mode below
    assign cls = hwl_pkg::hwl_class_t'(ctrl_ff.mode[4:3]);
    assign sub = ctrl_ff.mode[2:0];

    // the external level is only trusted while on_sync is high; the
    // trigger source keeps edges six clocks apart and levels at least six
    // clocks long, otherwise the two-stage sync can drop an event
    always_comb begin
        act = '0;
        case (cls)
            hwl_pkg::HWL_CLS_FREE: begin
                case (sub)
                    // RULE_05: software gate
                    3'h0: act.run = on_sync;
                    // RULE_07: hardware gate high / low
                    3'h1: act.run = on_sync & ers_eff_ff;
                    3'h2: act.run = on_sync & ~ers_eff_ff;
                    // RULE_09: level reset, low or high
                    3'h6: begin
                        act.run = on_sync & ers_eff_ff;
                        act.clear = on_sync & ~ers_eff_ff;
                    end
                    3'h7: begin
                        act.run = on_sync & ~ers_eff_ff;
                        act.clear = on_sync & ers_eff_ff;
                    end
                    // RULE_08: edge reset, either / rising / falling
                    default: begin
                        act.run = on_sync;
                        act.clear = (sub == 3'h3) ? (rise | fall) :
                            (sub == 3'h4) ? rise : fall;
                    end
                endcase
            end
            hwl_pkg::HWL_CLS_ONESHOT: begin
                act.stop_on_match = 1'b1;
                act.drop_run_enable = 1'b1;
                case (sub)
                    // RULE_10: software start
                    3'h0: act.run = on_sync;
                    // RULE_11: edge start, no later reset
                    3'h1, 3'h2, 3'h3: begin
                        act.arm = edge_sel(sub[1:0], rise, fall);
                        act.run = on_sync & armed_ff;
                    end
                    // RULE_12: first edge starts, later ones reset
                    3'h4, 3'h5: begin
                        act.arm = (sub == 3'h4) ? rise : fall;
                        act.clear = armed_ff & act.arm;
                        act.run = on_sync & armed_ff;
                    end
                    // RULE_13: rising start with low reset, or reverse
                    default: begin
                        act.arm = (sub == 3'h6) ? rise : fall;
                        act.clear = on_sync &
                            ((sub == 3'h6) ? ~ers_eff_ff : ers_eff_ff);
                        act.run = on_sync & armed_ff & ~act.clear;
                    end
                endcase
            end
            hwl_pkg::HWL_CLS_MONO: begin
                case (sub)
                    // RULE_15: monostable edge start, run-enable kept
                    3'h1, 3'h2, 3'h3: begin
                        act.stop_on_match = 1'b1;
                        act.arm = edge_sel(sub[1:0], rise, fall);
                        act.run = on_sync & armed_ff;
                    end
                    // RULE_16: level one-shot, high or low active
                    // RULE_22: release resumes after the sync delay
                    3'h6, 3'h7: begin
                        act.stop_on_match = 1'b1;
                        act.drop_run_enable = 1'b1;
                        act.clear = on_sync &
                            ((sub == 3'h6) ? ~ers_eff_ff : ers_eff_ff);
                        act.run = on_sync & ~act.clear;
                    end
                    // RULE_18: reserved sub-modes stay stopped
                    default: act = '0;
                endcase
            end
            // RULE_18: reserved class stays stopped
            default: act = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // start tracking for edge-started modes
    // ----------------------------------------------------------------
    // RULE_17: cleared with run-enable, so a fresh edge is needed
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed_ff <= 1'b0;
        end else if (!on_sync || wr_ctrl) begin
            armed_ff <= 1'b0;
        end else if (act.stop_on_match && match && act.run) begin
            armed_ff <= 1'b0;
        end else if (act.arm) begin
            armed_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // RULE_21: count cleared on reset
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_ff <= '0;
        end else if (wr_count) begin
            count_ff <= pwdata_i[CNT_W-1:0];
        end else if (act.clear) begin
            count_ff <= '0;
        // RULE_06: free-running returns to zero and continues
        // RULE_14: one-shot stops at zero after match
        end else if (act.run && match) begin
            count_ff <= '0;
        end else if (act.run) begin
            count_ff <= count_ff + CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // period match and postscaler
    // ----------------------------------------------------------------
    // RULE_20: one-clock pulse when postscaler hits its setting
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            post_cnt_ff <= '0;
            post_pulse_ff <= 1'b0;
            match_pulse_ff <= 1'b0;
        end else begin
            match_pulse_ff <= act.run & match;
            post_pulse_ff <= 1'b0;
            if (wr_ctrl || wr_count || act.clear) begin
                post_cnt_ff <= '0;
            end else if (act.run && match) begin
                if (post_cnt_ff == ctrl_ff.postscale_select) begin
                    post_pulse_ff <= 1'b1;
                    post_cnt_ff <= '0;
                end else begin
                    post_cnt_ff <= post_cnt_ff + POST_W'(1);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign count_value_o = count_ff;
    assign period_match_o = match_pulse_ff;
    assign postscaled_o = post_pulse_ff;

endmodule // hwl_timer_mode_ctrl
`default_nettype wire

// File: hwl_timer_mode_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------
// port checks for the mode control
// --------------------------------
module hwl_timer_mode_ctrl_asserts #(
    parameter int CNT_W = 8
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [CNT_W-1:0] count_value_o,
    input wire logic period_match_o,
    input wire logic postscaled_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    // exactly one wait state after the access phase opens
    a_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("pready not one cycle after penable");
    a_ready_cause: assert property (
        pready_o |-> $past(psel_i) && $past(penable_i))
        else $error("pready without an access phase");
    a_err_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("refused access without ready or with data");
    a_post_match: assert property (postscaled_o |-> period_match_o)
        else $error("postscaled pulse without period match");
    a_post_pulse: assert property (postscaled_o |=> !postscaled_o)
        else $error("postscaled pulse wider than one clock");
    a_match_zero: assert property (
        period_match_o |-> count_value_o == '0)
        else $error("count not zero at period match");
    // outside register writes the count only steps by one or clears
    a_count_step: assert property (
        (count_value_o != $past(count_value_o)) &&
        !($past(psel_i) && $past(pwrite_i))
        |-> (count_value_o == $past(count_value_o) + CNT_W'(1)) ||
        (count_value_o == '0))
        else $error("count jumped");
endmodule // hwl_timer_mode_ctrl_asserts
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock_i, arst_n_i, psel_i, penable_i, pwrite_i, debug_mode_i;
    logic [7:0] paddr_i, count_value_o, hold_q;
    logic [31:0] pwdata_i, prdata_o, rd_q;
    logic pready_o, pslverr_o, ext_w, period_match_o, postscaled_o, err_q;
    int err_count = 0;
    int n_compared = 0;
    int mx, nm, np;
    logic [7:0] rsv [3] = '{8'h90, 8'h94, 8'h98};

    hwl_timer_mode_ctrl #(.CNT_W(8), .POST_W(4)) hwl_timer_mode_ctrl_i (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .ext_reset_trigger_i(ext_w),
        .debug_mode_i(debug_mode_i), .count_value_o(count_value_o),
        .period_match_o(period_match_o), .postscaled_o(postscaled_o));
    hwl_ers_src hwl_ers_src_i (.clock_i(clock_i), .ers_o(ext_w));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock_i);
            if (pready_o === 1'b1) break;
        end
        if (n == 20) begin
            chk(32'h0, 32'h1);
            test_done();
        end
        rd_q = prdata_o;
        err_q = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask

    // let cycles pass, tracking the peak count and match pulses
    task automatic run(input int n);
        mx = 0;
        nm = 0;
        np = 0;
        repeat (n) begin
            @(posedge clock_i);
            if (count_value_o > mx) mx = count_value_o;
            if (period_match_o === 1'b1) nm++;
            if (postscaled_o === 1'b1) np++;
        end
    endtask

    // hold reset three cycles with the bus and debug idle
    task automatic rst();
        arst_n_i <= 1'b0;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        debug_mode_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(posedge clock_i);
    endtask

    task automatic setup(input logic [7:0] per, input logic [7:0] ctl);
        apb(1'b1, 8'h04, {24'h0, per});
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, {24'h0, ctl});
    endtask

    task automatic t_reset();
        apb(1'b0, 8'h04, 32'h0);
        chk(rd_q, 32'h000000ff);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b1, 8'h10, 32'h1);
        chk({31'h0, err_q}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        $display("reset and refusal done");
    endtask

    task automatic t_gates();
        // postscale setting 1: every second match gives a pulse
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h180);
        run(12);
        chk(mx, 2);
        chk(nm, 3);
        chk(np, 1);
        apb(1'b1, 8'h00, 32'h0);
        run(3);
        hold_q = count_value_o;
        run(6);
        chk(count_value_o, hold_q);
        hwl_ers_src_i.drive(1'b0);
        setup(8'hff, 8'h81);
        run(8);
        chk(count_value_o, 8'h00);
        hwl_ers_src_i.drive(1'b1);
        run(8);
        chk(count_value_o != 8'h00, 32'h1);
        $display("gate modes done");
    endtask

    task automatic t_limits();
        hwl_ers_src_i.drive(1'b0);
        setup(8'hff, 8'h84);
        run(25);
        chk(count_value_o >= 8'd15, 32'h1);
        hwl_ers_src_i.drive(1'b1);
        run(6);
        chk(count_value_o < 8'd8, 32'h1);
        hwl_ers_src_i.drive(1'b0);
        setup(8'hff, 8'h86);
        run(8);
        chk(count_value_o, 8'h00);
        hwl_ers_src_i.drive(1'b1);
        run(8);
        chk(count_value_o != 8'h00, 32'h1);
        $display("hardware limit modes done");
    endtask

    task automatic t_shots();
        setup(8'h03, 8'h88);
        run(15);
        chk(nm, 1);
        chk(count_value_o, 8'h00);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd_q, 32'h00000008);
        hwl_ers_src_i.drive(1'b0);
        setup(8'h03, 8'h91);
        run(10);
        chk(count_value_o, 8'h00);
        repeat (2) begin
            hwl_ers_src_i.drive(1'b1);
            run(12);
            chk(nm, 1);
            apb(1'b0, 8'h00, 32'h0);
            chk(rd_q, 32'h00000091);
            hwl_ers_src_i.drive(1'b0);
        end
        $display("one-shot and monostable done");
    endtask

    task automatic t_ignore();
        debug_mode_i <= 1'b1;
        setup(8'h03, 8'h89);
        hwl_ers_src_i.drive(1'b1);
        run(10);
        chk(count_value_o, 8'h00);
        chk(nm, 0);
        apb(1'b1, 8'h00, 32'h0);
        debug_mode_i <= 1'b0;
        foreach (rsv[i]) begin
            apb(1'b1, 8'h08, 32'h5);
            apb(1'b1, 8'h00, {24'h0, rsv[i]});
            run(6);
            chk(count_value_o, 8'h05);
        end
        $display("debug and reserved modes done");
    endtask

    initial begin
        rst();
        t_reset();
        t_gates();
        t_limits();
        t_shots();
        t_ignore();
        // a reset in mid-run must restore period and count again
        rst();
        t_reset();
        test_done();
    end
endmodule // tb_top

bind hwl_timer_mode_ctrl hwl_timer_mode_ctrl_asserts #(.CNT_W(CNT_W))
    hwl_chk_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .count_value_o(count_value_o), .period_match_o(period_match_o),
    .postscaled_o(postscaled_o));
`default_nettype wire
